// *** sra_pin_sync.sv ***
/*
 Two-stage synchroniser with edge detection for a group of pins.
 Assumes pins are asynchronous to clk_sys; edges are seen two clocks late at most.
*/
`timescale 1ns/100ps
module sra_pin_sync #(
   parameter int W = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [W-1:0] pinRaw,
   output logic [W-1:0] pinLevel,
   output logic [W-1:0] pinRise,
   output logic [W-1:0] pinFall
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;

   // Reset and select idle high, clock and data low; reset values avoid false edges
   localparam logic [W-1:0] IDLE = {1'b1, 1'b1, 1'b0, 1'b0};

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta <= IDLE;
         pinLevel <= IDLE;
         prev <= IDLE;
      end else if (clkEn) begin
         meta <= pinRaw;
         pinLevel <= meta;
         prev <= pinLevel;
      end
   end

   assign pinRise = pinLevel & ~prev;
   assign pinFall = ~pinLevel & prev;
endmodule : sra_pin_sync

// *** sra_pkg.sv ***
/*
 Constants, carrier types and address decode helpers for the serial register access block.
 Assumes a 128 byte register space behind one serial slave and a 250 MHz system clock.
*/
package sra_pkg;
   // ---------------------------------------------------------------
   // Widths and frame lengths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 128;
   localparam int CNT_W = 6;
   localparam int MAX_DATA_BYTES = 3;
   localparam logic [CNT_W-1:0] BITS_ADDR = 6'h08;
   localparam logic [CNT_W-1:0] BITS_2B = 6'h10;
   localparam logic [CNT_W-1:0] BITS_3B = 6'h18;
   localparam logic [CNT_W-1:0] BITS_4B = 6'h20;
   localparam logic [CNT_W-1:0] BITS_SAT = 6'h3F;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] A_WDOG = 7'h00;
   localparam logic [6:0] A_MODE = 7'h01;
   localparam logic [6:0] A_MAIN = 7'h03;
   localparam logic [6:0] A_SYSEN = 7'h04;
   localparam logic [6:0] A_WDST = 7'h05;
   localparam logic [6:0] A_MEM0 = 7'h06;
   localparam logic [6:0] A_MEM3 = 7'h09;
   localparam logic [6:0] A_LOCK = 7'h0A;
   localparam logic [6:0] A_REGC = 7'h10;
   localparam logic [6:0] A_SUPST = 7'h1B;
   localparam logic [6:0] A_SUPEN = 7'h1C;
   localparam logic [6:0] A_TRXC = 7'h20;
   localparam logic [6:0] A_TRXST = 7'h22;
   localparam logic [6:0] A_TRXEN = 7'h23;
   localparam logic [6:0] A_GLOB = 7'h60;
   localparam logic [6:0] A_SYSEV = 7'h61;
   localparam logic [6:0] A_SUPEV = 7'h62;
   localparam logic [6:0] A_TRXEV = 7'h63;
   localparam logic [6:0] A_NVST = 7'h70;

   // ---------------------------------------------------------------
   // Lock areas, field positions and reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] LK1_LO = 7'h10;
   localparam logic [6:0] LK1_HI = 7'h1F;
   localparam logic [6:0] LK2_LO = 7'h20;
   localparam logic [6:0] LK2_HI = 7'h2F;
   localparam logic [6:0] LK3_LO = 7'h30;
   localparam logic [6:0] LK3_HI = 7'h3F;
   localparam logic [6:0] LK4_LO = 7'h40;
   localparam logic [6:0] LK4_HI = 7'h4F;
   localparam logic [6:0] LK5_LO = 7'h50;
   localparam logic [6:0] LK5_HI = 7'h5F;
   localparam logic [6:0] LK6_LO = 7'h68;
   localparam logic [6:0] LK6_HI = 7'h6F;
   localparam int LOCK_RSVD_BIT = 7;
   localparam logic [7:0] LOCK_MASK = 8'h7F;
   localparam int FAIL_BIT = 1;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int POST_RESET_DELAY_NS = 2000;
   localparam int POST_RESET_CYCLES = (POST_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_W = 12;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic resetPinN;
      logic chipSelectN;
      logic serialClk;
      logic serialIn;
   } sra_pins_t;

   typedef struct packed {
      logic serialOut;
      logic serialOutEn;
   } sra_spi_out_t;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } sra_hw_write_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_SKIP = 2'b10,
      ST_DONE = 2'b11
   } sra_state_t;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic inRange(logic [6:0] a, logic [6:0] lo, logic [6:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction : inRange

   function automatic logic lockHit(logic [6:0] a, logic [7:0] lk);
      lockHit = (lk[0] && inRange(a, A_MEM0, A_MEM3))
         || (lk[1] && inRange(a, LK1_LO, LK1_HI))
         || (lk[2] && inRange(a, LK2_LO, LK2_HI))
         || (lk[3] && inRange(a, LK3_LO, LK3_HI))
         || (lk[4] && inRange(a, LK4_LO, LK4_HI))
         || (lk[5] && inRange(a, LK5_LO, LK5_HI))
         || (lk[6] && inRange(a, LK6_LO, LK6_HI));
   endfunction : lockHit

   // Status registers are hardware owned; holes in the map are not writable
   function automatic logic spiWritable(logic [6:0] a);
      case (a)
         A_WDOG, A_MODE, A_SYSEN, A_LOCK, A_REGC, A_SUPEN, A_TRXC, A_TRXEN: spiWritable = 1'b1;
         default: spiWritable = inRange(a, A_MEM0, A_MEM3) || inRange(a, A_GLOB, A_TRXEV);
      endcase
   endfunction : spiWritable

   function automatic logic isEventFlags(logic [6:0] a);
      isEventFlags = inRange(a, A_GLOB, A_TRXEV);
   endfunction : isEventFlags
endpackage : sra_pkg

// *** sra_spi_master.sv ***
/*
 Behavioural serial master standing in for the host controller.
 Assumes clk_sys at 250 MHz; each serial clock half period is four clk_sys cycles.
*/
`timescale 1ns/100ps
module sra_spi_master (
   input wire logic clk_sys,
   input wire sra_pkg::sra_spi_out_t spiOut,
   output sra_pkg::sra_pins_t pins
);
   logic serialLine;
   // Floats while the device is not driving
   assign serialLine = spiOut.serialOutEn ? spiOut.serialOut : 1'bz;
   initial begin
      pins = 4'b1100;
   end
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask : half
   task automatic pulseReset();
      pins.resetPinN <= 1'b0;
      half();
      pins.resetPinN <= 1'b1;
   endtask : pulseReset
   task automatic frame(input int nBits, input logic [63:0] tx, output logic [63:0] rx);
      rx = '0;
      @(posedge clk_sys);
      pins.chipSelectN <= 1'b0;
      half();
      for (int i = nBits - 1; i >= 0; i--) begin
         pins.serialClk <= 1'b1;
         pins.serialIn <= tx[i];
         half();
         pins.serialClk <= 1'b0;
         half();
         // Sampled late in the low phase: output holds until the next rise
         rx[i] = serialLine;
      end
      pins.chipSelectN <= 1'b1;
      pins.serialIn <= ~tx[0];
      half();
      half();
   endtask : frame
endmodule : sra_spi_master

// *** sra_spi_regs.sv ***
/*
 Serial slave front end with a 128 byte register space, write locks and user memory.
 Assumes the serial pins and reset pin are asynchronous and sampled here, the serial
 clock is much slower than clk_sys, and hardware status updates arrive on hwWrite.
*/
`timescale 1ns/100ps
module sra_spi_regs #(
   parameter int POST_RESET_CYCLES = sra_pkg::POST_RESET_CYCLES
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clkEn,
   input wire sra_pkg::sra_pins_t pinsIn,
   input wire logic modeChange,
   input wire sra_pkg::sra_hw_write_t hwWrite,
   output sra_pkg::sra_spi_out_t spiOut,
   output logic [7:0] lockState,
   output logic [31:0] userMemory,
   output logic failureEvent,
   output logic accessBlocked
);
   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   logic [3:0] lvlVec;
   logic [3:0] riseVec;
   logic [3:0] fallVec;
   sra_pkg::sra_pins_t pinLvl;
   sra_pkg::sra_pins_t pinRise;
   sra_pkg::sra_pins_t pinFall;

   sra_pin_sync #(.W(4)) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .clkEn(clkEn),
      .pinRaw(pinsIn),
      .pinLevel(lvlVec),
      .pinRise(riseVec),
      .pinFall(fallVec)
   );

   assign pinLvl = lvlVec;
   assign pinRise = riseVec;
   assign pinFall = fallVec;

   logic csLow;
   logic csFall;
   logic csRise;
   logic sckRise;
   logic sckFall;
   assign csLow = !pinLvl.chipSelectN;
   assign csFall = pinFall.chipSelectN;
   assign csRise = pinRise.chipSelectN;
   assign sckRise = pinRise.serialClk && csLow;
   assign sckFall = pinFall.serialClk && csLow;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [7:0] regFile [sra_pkg::REG_COUNT];
   sra_pkg::sra_state_t state;
   logic [sra_pkg::CNT_W-1:0] bitCnt;
   logic [7:0] inSr;
   logic [7:0] outSr;
   logic [6:0] baseAddr;
   logic roFlag;
   logic roKnown;
   logic [7:0] wrBuf [sra_pkg::MAX_DATA_BYTES];
   logic [sra_pkg::DLY_W-1:0] delayCnt;

   // ---------------------------------------------------------------
   // Combinational frame decode
   // ---------------------------------------------------------------
   logic [sra_pkg::CNT_W-1:0] next_bitCnt;
   logic [7:0] shiftedIn;
   logic [7:0] readAddr;
   logic [7:0] readByte;
   logic lenOk;
   logic isRead;
   logic doCommit;
   logic failSet;
   logic [7:0] wrAddr [sra_pkg::MAX_DATA_BYTES];
   logic [sra_pkg::MAX_DATA_BYTES-1:0] wrEn;

   assign next_bitCnt = (bitCnt == sra_pkg::BITS_SAT) ? bitCnt : bitCnt + 6'h01;
   assign shiftedIn = {inSr[6:0], pinLvl.serialIn};

   // Next readback byte: the base at the address byte, then one further per byte
   always_comb begin
      readAddr = 8'h00;
      if (next_bitCnt == sra_pkg::BITS_ADDR) begin
         readAddr = {1'b0, inSr[6:0]};
      end else begin
         readAddr = {1'b0, baseAddr} + {5'h00, next_bitCnt[5:3]} - 8'h01;
      end
   end

   // Bytes past the top of the map read as zero
   assign readByte = readAddr[7] ? 8'h00 : regFile[readAddr[6:0]];

   assign lenOk = (bitCnt == sra_pkg::BITS_2B) || (bitCnt == sra_pkg::BITS_3B)
      || (bitCnt == sra_pkg::BITS_4B);
   assign isRead = roKnown && roFlag;
   assign doCommit = (state == sra_pkg::ST_DONE) && lenOk && !isRead;
   // A frame too short to carry the flag is counted as a failed write
   assign failSet = (state == sra_pkg::ST_DONE) && !lenOk && !isRead;
   always_comb begin
      for (int i = 0; i < sra_pkg::MAX_DATA_BYTES; i++) begin
         wrAddr[i] = {1'b0, baseAddr} + 8'(i);
         wrEn[i] = doCommit && (i < int'(bitCnt[5:3]) - 1)
            && !wrAddr[i][7]
            && sra_pkg::spiWritable(wrAddr[i][6:0])
            && !sra_pkg::lockHit(wrAddr[i][6:0],
               regFile[sra_pkg::A_LOCK]);
      end
   end

   // ---------------------------------------------------------------
   // Access block after the reset pin
   // ---------------------------------------------------------------
   // Held while the reset pin is low and for the delay after it rises
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         delayCnt <= '0;
         accessBlocked <= 1'b0;
      end else if (clkEn) begin
         if (!pinLvl.resetPinN) begin
            delayCnt <= sra_pkg::DLY_W'(POST_RESET_CYCLES);
            accessBlocked <= 1'b1;
         end else if (delayCnt != '0) begin
            delayCnt <= delayCnt - 1'b1;
            accessBlocked <= (delayCnt > sra_pkg::DLY_W'(1));
         end else begin
            accessBlocked <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame state
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= sra_pkg::ST_IDLE;
      end else if (clkEn) begin
         if (csFall) begin
            state <= accessBlocked ? sra_pkg::ST_SKIP : sra_pkg::ST_SHIFT;
         end else if (state == sra_pkg::ST_SHIFT && modeChange) begin
            state <= sra_pkg::ST_SKIP;
         end else if (csRise) begin
            state <= (state == sra_pkg::ST_SHIFT) ? sra_pkg::ST_DONE : sra_pkg::ST_IDLE;
         end else if (state == sra_pkg::ST_DONE) begin
            state <= sra_pkg::ST_IDLE;
         end
      end
   end

   // ---------------------------------------------------------------
   // Shift path
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bitCnt <= '0;
         inSr <= 8'h00;
         outSr <= 8'h00;
         baseAddr <= 7'h00;
         roFlag <= 1'b0;
         roKnown <= 1'b0;
         for (int i = 0; i < sra_pkg::MAX_DATA_BYTES; i++) begin
            wrBuf[i] <= 8'h00;
         end
      end else if (clkEn) begin
         if (csFall) begin
            bitCnt <= '0;
            outSr <= 8'h00;
            roFlag <= 1'b0;
            roKnown <= 1'b0;
         end else if (sckFall) begin
            bitCnt <= next_bitCnt;
            inSr <= shiftedIn;
            if (next_bitCnt == sra_pkg::BITS_ADDR) begin
               baseAddr <= inSr[6:0];
               roFlag <= pinLvl.serialIn;
               roKnown <= 1'b1;
            end
            if (next_bitCnt[2:0] == 3'h0 && next_bitCnt >= sra_pkg::BITS_2B
               && next_bitCnt <= sra_pkg::BITS_4B) begin
               wrBuf[next_bitCnt[4:3] - 2'h2] <= shiftedIn;
            end
            if (next_bitCnt[2:0] == 3'h0 && next_bitCnt <= sra_pkg::BITS_3B) begin
               outSr <= readByte;
            end
         end else if (sckRise) begin
            outSr <= {outSr[6:0], 1'b0};
         end
      end
   end

   // Output enable follows the select so the line floats outside frames
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         spiOut <= '0;
      end else if (clkEn) begin
         spiOut.serialOutEn <= csLow;
         if (csFall) begin
            spiOut.serialOut <= 1'b0;
         end else if (sckRise) begin
            if (isRead && bitCnt >= sra_pkg::BITS_4B) begin
               spiOut.serialOut <= pinLvl.serialIn;
            end else begin
               spiOut.serialOut <= outSr[7];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Later assignments win: hardware updates after the serial write and the
   // failure flag last, so an event in the clearing cycle is kept.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int a = 0; a < sra_pkg::REG_COUNT; a++) begin
            regFile[a] <= sra_pkg::REG_RESET;
         end
      end else if (clkEn) begin
         for (int i = 0; i < sra_pkg::MAX_DATA_BYTES; i++) begin
            if (wrEn[i]) begin
               if (sra_pkg::isEventFlags(wrAddr[i][6:0])) begin
                  regFile[wrAddr[i][6:0]] <= regFile[wrAddr[i][6:0]] & ~wrBuf[i];
               end else if (wrAddr[i][6:0] == sra_pkg::A_LOCK) begin
                  regFile[wrAddr[i][6:0]] <= wrBuf[i] & sra_pkg::LOCK_MASK;
               end else begin
                  regFile[wrAddr[i][6:0]] <= wrBuf[i];
               end
            end
         end
         if (hwWrite.valid && hwWrite.addr == sra_pkg::A_LOCK) begin
            // Reserved lock bit stays zero whoever writes the register
            regFile[hwWrite.addr] <= hwWrite.data & sra_pkg::LOCK_MASK;
         end else if (hwWrite.valid) begin
            regFile[hwWrite.addr] <= hwWrite.data;
         end
         if (failSet) begin
            regFile[sra_pkg::A_SYSEV][sra_pkg::FAIL_BIT] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign lockState = regFile[sra_pkg::A_LOCK];
   assign userMemory = {regFile[sra_pkg::A_MEM3], regFile[sra_pkg::A_MEM0 + 7'h02],
      regFile[sra_pkg::A_MEM0 + 7'h01], regFile[sra_pkg::A_MEM0]};
   assign failureEvent = regFile[sra_pkg::A_SYSEV][sra_pkg::FAIL_BIT];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   property p_oe_off;
      clkEn && pinLvl.chipSelectN ##1 clkEn |-> !spiOut.serialOutEn;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output enabled with select high");

   property p_lock_rsvd;
      regFile[sra_pkg::A_LOCK][sra_pkg::LOCK_RSVD_BIT] == 1'b0;
   endproperty
   a_lock_rsvd: assert property (p_lock_rsvd) else $error("lock bit 7 not zero");

   property p_fail_len;
      clkEn && failSet |=> failureEvent;
   endproperty
   a_fail_len: assert property (p_fail_len) else $error("bad length not flagged");

   property p_good_len;
      clkEn && state == sra_pkg::ST_DONE && lenOk && !failureEvent && !hwWrite.valid
         |=> !failureEvent;
   endproperty
   a_good_len: assert property (p_good_len) else $error("good length raised failure");

   property p_ro_nowrite;
      clkEn && state == sra_pkg::ST_DONE && isRead && !hwWrite.valid
         |=> $stable(userMemory) && $stable(lockState) && $stable(failureEvent);
   endproperty
   a_ro_nowrite: assert property (p_ro_nowrite) else $error("read frame wrote");

   property p_mem_locked;
      clkEn && regFile[sra_pkg::A_LOCK][0] && !hwWrite.valid
         |=> $stable(userMemory);
   endproperty
   a_mem_locked: assert property (p_mem_locked) else $error("locked memory changed");

   property p_mode_skip;
      clkEn && state == sra_pkg::ST_SHIFT && modeChange && !csFall
         |=> state == sra_pkg::ST_SKIP ##1 !doCommit;
   endproperty
   a_mode_skip: assert property (p_mode_skip) else $error("mode change kept frame");

   property p_blocked_skip;
      clkEn && accessBlocked && csFall |=> state == sra_pkg::ST_SKIP;
   endproperty
   a_blocked_skip: assert property (p_blocked_skip) else $error("blocked frame taken");

   property p_echo;
      clkEn && sckRise && isRead && bitCnt >= sra_pkg::BITS_4B
         |=> spiOut.serialOut == $past(pinLvl.serialIn);
   endproperty
   a_echo: assert property (p_echo) else $error("input not echoed");

   c_write32: cover property (doCommit && bitCnt == sra_pkg::BITS_4B);
   c_fail: cover property (failSet);
   c_echo: cover property (sckRise && isRead && bitCnt >= sra_pkg::BITS_4B);
   c_locked: cover property (doCommit && wrEn != 3'h7 && bitCnt == sra_pkg::BITS_4B);
endmodule : sra_spi_regs

// *** tb_sra_spi_regs.sv ***
/*
 Self-checking bench for the serial register block.
 Assumes the master model drives every pin; hwWrite and modeChange come from here.
*/
`timescale 1ns/100ps
module tb_sra_spi_regs;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic modeChange = 1'b0;
   sra_pkg::sra_hw_write_t hwWrite = '0;
   sra_pkg::sra_pins_t pins;
   sra_pkg::sra_spi_out_t spiOut;
   logic [7:0] lockState;
   logic [31:0] userMemory;
   logic failureEvent;
   logic accessBlocked;
   logic [63:0] rx;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // Design and far side
   // ---------------------------------------------------------------
   sra_spi_regs #(.POST_RESET_CYCLES(8)) u_sra_spi_regs (
      .clk_sys(clk_sys), .srst(srst), .clkEn(1'b1), .pinsIn(pins), .modeChange(modeChange),
      .hwWrite(hwWrite), .spiOut(spiOut), .lockState(lockState), .userMemory(userMemory),
      .failureEvent(failureEvent), .accessBlocked(accessBlocked)
   );
   sra_spi_master u_sra_spi_master (.clk_sys(clk_sys), .spiOut(spiOut), .pins(pins));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // Generous ceiling; the whole sequence needs about 4150 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask : chk
   task automatic wr(input int n, input logic [63:0] tx);
      u_sra_spi_master.frame(n, tx, rx);
      repeat (4) @(posedge clk_sys);
   endtask : wr
   task automatic rd(input int n, input logic [63:0] tx, input logic [63:0] exp);
      u_sra_spi_master.frame(n, tx, rx);
      chk("readback", exp, rx);
   endtask : rd
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("userMemory", 64'h0, userMemory);
      u_sra_spi_master.pulseReset();
      chk("accessBlocked", 64'h1, accessBlocked);
      wr(16, 64'h0C77);
      chk("accessBlocked", 64'h0, accessBlocked);
      chk("userMemory", 64'h0, userMemory);
      chk("failureEvent", 64'h0, failureEvent);
      wr(32, 64'h0CA1B2C3);
      chk("userMemory", 64'hC3B2A1, userMemory);
      rd(32, 64'h0DFFFFFF, 64'hA1B2C3);
      rd(40, 64'h0D0000005A, 64'hA1B2C35A);
      chk("userMemory", 64'hC3B2A1, userMemory);
      chk("serialOutEn", 64'h0, spiOut.serialOutEn);
      wr(16, 64'h14FF);
      chk("lockState", 64'h7F, lockState);
      wr(16, 64'h1401);
      wr(24, 64'h125503);
      chk("userMemory", 64'hC3B2A1, userMemory);
      chk("lockState", 64'h03, lockState);
      hwWrite <= '{valid: 1'b1, addr: 7'h06, data: 8'h99};
      @(posedge clk_sys);
      hwWrite <= '{valid: 1'b1, addr: 7'h0A, data: 8'h83};
      @(posedge clk_sys);
      hwWrite <= '0;
      repeat (2) @(posedge clk_sys);
      chk("userMemory", 64'hC3B299, userMemory);
      chk("lockState", 64'h03, lockState);
      for (int i = 1; i <= 2; i++) begin
         wr(16, 64'h1400 | (64'h1 << i));
         wr(16, (64'h20 << (i - 1)) << 8 | 64'h3C);
         rd(16, ((64'h20 << (i - 1)) | 64'h1) << 8, 64'h00);
         wr(16, 64'h1400);
         wr(16, (64'h20 << (i - 1)) << 8 | 64'h3C);
         rd(16, ((64'h20 << (i - 1)) | 64'h1) << 8, 64'h3C);
      end
      wr(20, 64'h0C123);
      chk("failureEvent", 64'h1, failureEvent);
      chk("userMemory", 64'hC3B299, userMemory);
      wr(16, 64'hC202);
      chk("failureEvent", 64'h0, failureEvent);
      wr(32, 64'hFC111111);
      wr(16, 64'h0411);
      chk("failureEvent", 64'h0, failureEvent);
      fork
         wr(16, 64'h0C44);
         begin
            repeat (60) @(posedge clk_sys);
            modeChange <= 1'b1;
            @(posedge clk_sys);
            modeChange <= 1'b0;
         end
      join
      chk("userMemory", 64'hC3B299, userMemory);
      end_of_test();
   end
endmodule : tb_sra_spi_regs
